// *** bench/adsq_core_model.sv ***
// Purpose: Analog core stand-in
// Assumes: Sample valid only while converting
// Notes:   Idle output keeps moving so nothing stale looks valid
`timescale 1ns/100ps
module adsq_core_model
  import adsq_pkg::*;
(
  input  wire logic            clock,
  input  wire logic            convRun,
  input  wire logic [CH_W-1:0] convChannel,
  input  wire logic [4:0]      sampleTag,
  output logic [RES_W-1:0]     convSample
);
  logic [RES_W-1:0] junk = 10'h2a5;
  always @(posedge clock) junk <= ~junk + 10'h1;
  assign convSample = convRun ? {convChannel, sampleTag} : junk;
endmodule : adsq_core_model

// *** bench/adsq_props.sv ***
// Purpose: Port checks for the sequencer
// Assumes: Mode bits mirrored from APB writes
// Notes:   Result check not covered here
`timescale 1ns/100ps
module adsq_props
  import adsq_pkg::*;
(
  input wire logic            clock,
  input wire logic            nrst,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [7:0]      paddr,
  input wire logic [31:0]     pwdata,
  input wire logic            hwTrigger,
  input wire logic            convRun,
  input wire logic [CH_W-1:0] convChannel,
  input wire logic            conversionEndIrq,
  input wire logic            irq
);
  logic [5:0]      ctl;
  logic [CH_W-1:0] chs;
  logic            msk;
  logic [15:0]     cnt;
  wire             wr = psel & penable & pwrite;
  wire             ctWr = wr && paddr == OFF_CTRL;
  wire             chWr = wr && paddr == OFF_CHSEL;
  wire [CH_W-1:0]  last = chs + 5'h3;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctl <= '0;
      chs <= '0;
      msk <= 1'b0;
    end else begin
      if (ctWr) ctl <= pwdata[5:0];
      if (chWr) chs <= pwdata[CH_W-1:0];
      if (wr && paddr == OFF_MASK) msk <= pwdata[STS_EOC];
    end
  end
  // Every restart zeroes the count on the same edge as the design
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) cnt <= '0;
    else if (!convRun || hwTrigger || ctWr || chWr || cnt == CONV_CYCLES - 16'h1) cnt <= '0;
    else cnt <= cnt + 16'h1;
  end
  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);
  sequence s_restart;
    convRun && (hwTrigger && !ctWr || ctWr && pwdata[CTRL_START] && pwdata[CTRL_ENABLE]);
  endsequence
  sequence s_chWrite;
    convRun && chWr && ctl[CTRL_ENABLE];
  endsequence
  property p_start; $rose(convRun) |-> $past(hwTrigger) && convChannel == chs; endproperty
  a_start: assert property (p_start) else $error("start without trigger");
  property p_time; conversionEndIrq |-> $past(cnt) == CONV_CYCLES - 16'h1; endproperty
  a_time: assert property (p_time) else $error("end at wrong time");
  property p_irq; conversionEndIrq && msk |-> irq; endproperty
  a_irq: assert property (p_irq) else $error("irq low");
  property p_seq; conversionEndIrq && !ctl[CTRL_ONESHOT] |-> convRun; endproperty
  a_seq: assert property (p_seq) else $error("sequence stopped");
  property p_one;
    conversionEndIrq && ctl[CTRL_ONESHOT] && (!ctl[CTRL_SCAN] || $past(convChannel) == last)
      |-> !convRun;
  endproperty
  a_one: assert property (p_one) else $error("one-shot kept running");
  property p_scan;
    conversionEndIrq && ctl[CTRL_SCAN] && convRun
      |-> convChannel == ($past(convChannel) == last ? chs : $past(convChannel) + 5'h1);
  endproperty
  a_scan: assert property (p_scan) else $error("scan order");
  property p_restart; s_restart |=> convRun && convChannel == chs; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_chsel; s_chWrite |=> convRun && convChannel == $past(pwdata[CH_W-1:0]); endproperty
  a_chsel: assert property (p_chsel) else $error("channel not taken");
  property p_stop; convRun && ctWr && !pwdata[CTRL_START] |=> !convRun; endproperty
  a_stop: assert property (p_stop) else $error("clear did not stop");
endmodule : adsq_props
bind adsq_sequencer adsq_props u_props (.clock(clock), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hwTrigger(hwTrigger),
  .convRun(convRun), .convChannel(convChannel), .conversionEndIrq(conversionEndIrq), .irq(irq));

// *** bench/adsq_sequencer_tb.sv ***
// Purpose: Self-checking bench for the sequencer
// Assumes: Core stand-in answers {channel, tag}
// Notes:   About 4000 cycles
`timescale 1ns/100ps
module adsq_sequencer_tb
  import adsq_pkg::*;
;
  logic             clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0, hwTrigger = 0;
  logic             pready, pslverr, convRun, conversionEndIrq, irq, err;
  logic [7:0]       paddr = '0;
  logic [31:0]      pwdata = '0, prdata, rd;
  logic [CH_W-1:0]  convChannel, base;
  logic [RES_W-1:0] convSample;
  logic [4:0]       tag;
  int               fail_count = 0, n_compared = 0, cyc = 0, n;
  always #5 clock = ~clock;
  adsq_sequencer dut (.clock(clock), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hwTrigger(hwTrigger), .convSample(convSample), .convRun(convRun),
    .convChannel(convChannel), .conversionEndIrq(conversionEndIrq), .irq(irq));
  adsq_core_model core (.clock(clock), .convRun(convRun), .convChannel(convChannel),
    .sampleTag(tag), .convSample(convSample));
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock) penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic trig();
    @(posedge clock) hwTrigger <= 1'b1;
    @(posedge clock) hwTrigger <= 1'b0;
  endtask : trig
  // Waits for the next stored result, then reads it back
  task automatic res(int ch);
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (conversionEndIrq !== 1'b1 && n < 300);
    check("end pulse", conversionEndIrq, 1'b1);
    apb(0, OFF_RESULT, 0);
    check("result", rd, {22'h0, CH_W'(ch), tag});
  endtask : res
  always @(posedge clock) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      summarize();
    end
  end
  initial begin
    n = $urandom(32'h77f6);
    tag = 5'($urandom) | 5'h1;
    base = CH_W'($urandom);
    repeat (4) @(posedge clock);
    nrst <= 1'b1;
    apb(0, OFF_LIMIT, 0);
    check("limit", rd, {6'h0, UPPER_RESET, 6'h0, LOWER_RESET});
    apb(0, 8'h1c, 0);
    check("unmapped", rd | 32'(err), 32'h1);
    apb(1, OFF_MASK, 32'h1);
    trig();
    apb(0, OFF_STATE, 0);
    check("off", rd & 32'h7, 32'h0);
    apb(1, OFF_CHSEL, 32'(base));
    apb(1, OFF_CTRL, 32'h9);
    apb(0, OFF_STATE, 0);
    check("wait", rd & 32'h7, 32'h2);
    $display("test reset done");
    trig();
    apb(0, OFF_CTRL, 0);
    check("start", rd[CTRL_START], 1'b1);
    trig();
    res(base);
    check("length", n, CONV_CYCLES + 16'h1);
    check("irq", irq, 1'b1);
    apb(0, OFF_STATUS, 0);
    check("eoc", rd[STS_EOC], 1'b1);
    apb(0, OFF_CTRL, 0);
    check("oneshot", {irq, rd[CTRL_START], convRun}, 3'h0);
    trig();
    apb(1, OFF_CHSEL, 32'(base ^ 5'h10));
    res(base ^ 5'h10);
    $display("test select done");
    apb(1, OFF_CHSEL, 32'(base));
    apb(1, OFF_CTRL, 32'h5);
    trig();
    for (int k = 0; k < 6; k++) res(base + k % 4);
    apb(1, OFF_CTRL, 32'h7);
    res(base);
    trig();
    res(base);
    apb(1, OFF_CHSEL, 32'(base + 1));
    res(base + 1);
    apb(1, OFF_CTRL, 32'h5);
    apb(0, OFF_STATE, 0);
    check("halt", rd & 32'h7, 32'h2);
    apb(0, OFF_STATUS, 0);
    check("abort", rd[STS_ABORT], 1'b1);
    apb(1, OFF_CTRL, 32'hd);
    trig();
    for (int k = 1; k < 5; k++) res(base + k);
    apb(0, OFF_CTRL, 0);
    check("scan1", {rd[CTRL_START], convRun}, 2'h0);
    $display("test scan done");
    apb(0, OFF_STATUS, 0);
    apb(1, OFF_LIMIT, 0);
    apb(1, OFF_CTRL, 32'h39);
    trig();
    repeat (CONV_CYCLES + 16'h10) @(posedge clock);
    apb(0, OFF_RESULT, 0);
    check("kept", rd, {22'h0, CH_W'(base + 4), tag});
    apb(0, OFF_STATUS, 0);
    check("supp", rd & 32'h5, 32'h4);
    $display("test limits done");
    apb(1, OFF_CTRL, 32'h1);
    trig();
    res(base + 1);
    res(base + 1);
    apb(1, OFF_CTRL, 32'h1);
    apb(0, OFF_STATE, 0);
    check("seqstop", rd & 32'h7, 32'h2);
    $display("test sequential done");
    summarize();
  end
endmodule : adsq_sequencer_tb

// *** logic/adsq_pkg.sv ***
// Purpose: Constants for the hardware-trigger wait sequencer
// Assumes: 32-bit APB, word-aligned registers
// Notes:   Offsets are byte addresses
package adsq_pkg;
  localparam logic [7:0]  OFF_CTRL      = 8'h00;
  localparam logic [7:0]  OFF_CHSEL     = 8'h04;
  localparam logic [7:0]  OFF_RESULT    = 8'h08;
  localparam logic [7:0]  OFF_LIMIT     = 8'h0c;
  localparam logic [7:0]  OFF_STATUS    = 8'h10;
  localparam logic [7:0]  OFF_MASK      = 8'h14;
  localparam logic [7:0]  OFF_STATE     = 8'h18;
  // Control register fields
  localparam int          CTRL_ENABLE   = 0;
  localparam int          CTRL_START    = 1;
  localparam int          CTRL_SCAN     = 2;
  localparam int          CTRL_ONESHOT  = 3;
  localparam int          CTRL_CHECK    = 4;
  localparam int          CTRL_CHKIN    = 5;
  // Status register fields
  localparam int          STS_EOC       = 0;
  localparam int          STS_ABORT     = 1;
  localparam int          STS_SUPPRESS  = 2;
  localparam int          STS_W         = 3;
  localparam int          RES_W         = 10;
  localparam int          CH_W          = 5;
  localparam int          LIM_HI_LSB    = 16;
  localparam logic [1:0]  SCAN_LAST     = 2'h3;
  // One conversion lasts this long; the sequencer counts it out in CONV_CYCLES
  localparam int          CONV_TIME_NS  = 2000;
  localparam int          CLK_PERIOD_NS = 10;
  localparam logic [15:0] CONV_CYCLES   = 16'((CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [RES_W-1:0] UPPER_RESET = 10'h3ff;
  localparam logic [RES_W-1:0] LOWER_RESET = 10'h000;
  typedef enum logic [1:0] {ST_STOP, ST_WAIT, ST_CONV} adsq_state_e;
endpackage : adsq_pkg

// *** logic/adsq_sequencer.sv ***
// Purpose: Hardware-trigger wait mode sequencer with APB registers
// Assumes: Analog core delivers a sample when convDone pulses
// Notes:   Select and four-slot scan mode, sequential or one-shot
//
// Implementation choices: the APB slave port and the address map.
`timescale 1ns/100ps
module adsq_sequencer
  import adsq_pkg::*;
(
  input  wire logic              clock,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              hwTrigger,
  input  wire logic [RES_W-1:0]  convSample,
  output logic                   convRun,
  output logic [CH_W-1:0]        convChannel,
  output logic                   conversionEndIrq,
  output logic                   irq
);

  adsq_state_e           state_reg;
  logic [5:0]            ctrl_reg;
  logic [CH_W-1:0]       channelSelect_reg;
  logic [RES_W-1:0]      result_reg;
  logic [RES_W-1:0]      upperLimit_reg;
  logic [RES_W-1:0]      lowerLimit_reg;
  logic [STS_W-1:0]      status_reg;
  logic [STS_W-1:0]      mask_reg;
  logic [15:0]           convCount_reg;
  logic [1:0]            slot_reg;
  logic                  irqPulse_reg;

  logic                  wrEn;
  logic                  rdEn;
  logic                  ctrlWrite;
  logic                  chselWrite;
  logic                  startSetWr;
  logic                  startClrWr;
  logic                  enableClrWr;
  logic                  converting;
  logic                  convDone;
  logic                  restart;
  logic                  lastSlot;
  logic                  resultOk;
  logic                  abortEvt;
  logic [STS_W-1:0]      stsSet;
  logic                  limitWrite;
  logic                  maskWrite;
  logic                  statusRead;
  logic                  trigAccept;
  logic                  storeEvt;
  logic                  dropEvt;
  logic                  oneShotEnd;
  logic [31:0]           readWord;

  // Scan groups are four consecutive inputs starting at the selected base
  function automatic logic [CH_W-1:0] slotChannel(input logic [CH_W-1:0] base,
                                                  input logic [1:0]      slot,
                                                  input logic            scan);
    slotChannel = scan ? CH_W'(base + CH_W'(slot)) : base;
  endfunction : slotChannel

  function automatic logic inLimits(input logic [RES_W-1:0] v,
                                    input logic [RES_W-1:0] lo,
                                    input logic [RES_W-1:0] hi);
    inLimits = (v >= lo) && (v <= hi);
  endfunction : inLimits

  // Register hit for one access phase; the register write decodes and the status read decode go through here
  function automatic logic regHit(input logic       access,
                                  input logic [7:0] addr,
                                  input logic [7:0] offset);
    regHit = access && (addr == offset);
  endfunction : regHit

  // APB: zero wait states, unmapped offsets answer with pslverr
  assign pready      = 1'b1;
  assign wrEn        = psel && penable && pwrite;
  assign rdEn        = psel && penable && !pwrite;
  assign pslverr     = psel && penable && (paddr > OFF_STATE || paddr[1:0] != 2'h0);
  assign ctrlWrite   = regHit(wrEn, paddr, OFF_CTRL);
  assign chselWrite  = regHit(wrEn, paddr, OFF_CHSEL);
  assign limitWrite  = regHit(wrEn, paddr, OFF_LIMIT);
  assign maskWrite   = regHit(wrEn, paddr, OFF_MASK);
  assign statusRead  = regHit(rdEn, paddr, OFF_STATUS);
  assign startSetWr  = ctrlWrite && pwdata[CTRL_START];
  assign startClrWr  = ctrlWrite && !pwdata[CTRL_START];
  assign enableClrWr = ctrlWrite && !pwdata[CTRL_ENABLE];

  assign converting  = state_reg == ST_CONV;
  assign convDone    = converting && convCount_reg == CONV_CYCLES - 16'h1;
  assign lastSlot    = !ctrl_reg[CTRL_SCAN] || slot_reg == SCAN_LAST;
  // Checked against the limits in either inside or outside sense
  assign resultOk    = !ctrl_reg[CTRL_CHECK] ||
                       (inLimits(convSample, lowerLimit_reg, upperLimit_reg) ==
                        ctrl_reg[CTRL_CHKIN]);

  // Abort-and-restart causes, lower priority than clearing the start bit
  assign restart     = converting && !startClrWr && !enableClrWr &&
                       (startSetWr || chselWrite || hwTrigger);
  assign abortEvt    = converting && (restart || startClrWr || enableClrWr);

  // Trigger is accepted from wait; in conversion it restarts instead; an enable clear in the same cycle wins
  assign trigAccept  = state_reg == ST_WAIT && hwTrigger && ctrl_reg[CTRL_ENABLE] &&
                       !enableClrWr;
  // A conversion that ends while being aborted yields nothing
  assign storeEvt    = convDone && !abortEvt && resultOk;
  assign dropEvt     = convDone && !abortEvt && !resultOk;
  assign oneShotEnd  = convDone && !abortEvt && lastSlot && ctrl_reg[CTRL_ONESHOT];

  assign convRun     = converting;
  assign convChannel = slotChannel(channelSelect_reg, slot_reg, ctrl_reg[CTRL_SCAN]);
  assign conversionEndIrq = irqPulse_reg;
  assign irq         = |(status_reg & mask_reg);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      state_reg <= ST_STOP;
    end else begin
      case (state_reg)
        ST_STOP: begin
          if (ctrlWrite && pwdata[CTRL_ENABLE]) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (enableClrWr) begin
            state_reg <= ST_STOP;
          end else if (trigAccept) begin
            state_reg <= ST_CONV;
          end
        end
        ST_CONV: begin
          if (enableClrWr) begin
            state_reg <= ST_STOP;
          end else if (startClrWr) begin
            state_reg <= ST_WAIT;
          end else if (oneShotEnd) begin
            state_reg <= ST_WAIT;
          end
        end
        default: state_reg <= ST_STOP;
      endcase
    end
  end

  // Control bits; the start bit is also driven by the sequencer itself
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= 6'h00;
    end else if (ctrlWrite) begin
      ctrl_reg <= pwdata[5:0];
      if (!pwdata[CTRL_ENABLE]) begin
        ctrl_reg[CTRL_START] <= 1'b0;
      end else if (trigAccept) begin
        // A same-cycle trigger still starts, so the bit must follow it
        ctrl_reg[CTRL_START] <= 1'b1;
      end else if (state_reg != ST_CONV) begin
        // Start only follows a trigger in this mode
        ctrl_reg[CTRL_START] <= 1'b0;
      end
    end else if (trigAccept) begin
      ctrl_reg[CTRL_START] <= 1'b1;
    end else if (oneShotEnd) begin
      ctrl_reg[CTRL_START] <= 1'b0;
    end
  end

  // Scan base in scan mode, the converted input in select mode
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      channelSelect_reg <= '0;
    end else if (chselWrite) begin
      channelSelect_reg <= pwdata[CH_W-1:0];
    end
  end

  // Both limits are written together, so a check never sees half a pair
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lowerLimit_reg <= LOWER_RESET;
      upperLimit_reg <= UPPER_RESET;
    end else if (limitWrite) begin
      lowerLimit_reg <= pwdata[RES_W-1:0];
      upperLimit_reg <= pwdata[LIM_HI_LSB+RES_W-1:LIM_HI_LSB];
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_reg <= '0;
    end else if (maskWrite) begin
      mask_reg <= pwdata[STS_W-1:0];
    end
  end

  // Conversion timer; restart discards the partial count
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      convCount_reg <= 16'h0;
    end else if (!converting || abortEvt) begin
      convCount_reg <= 16'h0;
    end else if (convDone) begin
      convCount_reg <= 16'h0;
    end else begin
      convCount_reg <= 16'(convCount_reg + 16'h1);
    end
  end

  // Scan slot; any abort goes back to slot zero of the current group
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      slot_reg <= 2'h0;
    end else if (!converting || abortEvt) begin
      slot_reg <= 2'h0;
    end else if (convDone) begin
      slot_reg <= lastSlot ? 2'h0 : 2'(slot_reg + 2'h1);
    end
  end

  // A suppressed result leaves the previous one readable
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      result_reg <= '0;
    end else if (storeEvt) begin
      result_reg <= convSample;
    end
  end

  // Pulse and result change on one edge, so the result stands when the pulse is seen
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irqPulse_reg <= 1'b0;
    end else begin
      irqPulse_reg <= storeEvt;
    end
  end

  assign stsSet = {dropEvt, abortEvt, storeEvt};

  // Sticky events; read clears, but a same-cycle event survives
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      status_reg <= '0;
    end else if (statusRead) begin
      // Clear only what the read returned; an event in the setup cycle stays
      status_reg <= (status_reg & ~prdata[STS_W-1:0]) | stsSet;
    end else begin
      status_reg <= status_reg | stsSet;
    end
  end

  // Read data is captured in the setup cycle so it stands through the access phase
  always_comb begin
    readWord = 32'h0;
    case (paddr)
      OFF_CTRL: begin
        readWord = {26'h0, ctrl_reg};
      end
      OFF_CHSEL: begin
        readWord = {27'h0, channelSelect_reg};
      end
      OFF_RESULT: begin
        readWord = {22'h0, result_reg};
      end
      OFF_LIMIT: begin
        readWord = {6'h0, upperLimit_reg, 6'h0, lowerLimit_reg};
      end
      OFF_STATUS: begin
        readWord = {29'h0, status_reg};
      end
      OFF_MASK: begin
        readWord = {29'h0, mask_reg};
      end
      OFF_STATE: begin
        readWord = {22'h0, convChannel, slot_reg, state_reg, converting};
      end
      default: begin
        readWord = 32'h0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= readWord;
    end
  end

endmodule : adsq_sequencer
